// ---- core/brspc_pkg.sv ----
// shared constants and carriers for the serial rom pin control block
package brspc_pkg;
    localparam int CORE_CLK_HZ = 25000000;
    // least reset pulse width, in ns
    localparam int RESET_MIN_NS = 1000;
    localparam int CORE_PERIOD_NS = 1000000000 / CORE_CLK_HZ;
    localparam int RESET_MIN_CYC =
        (RESET_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    // port clock rates chosen by the strap
    localparam int ROM_SLOW_HZ = 30000000;
    localparam int ROM_FAST_HZ = 60000000;
    localparam logic STRAP_RESET = 1'h0;
    localparam logic STRAP_FAST = 1'h1;
    // synchroniser depth for pins from outside the clock domain
    localparam int SYNC_DEPTH = 2;
    // pin states while reset is held
    localparam logic SEL_RESET = 1'h1;
    localparam logic CLK_RESET = 1'h0;
    localparam logic SERIAL_IN_RESET = 1'h0;
    localparam logic SI_PULL_RESET = 1'h1;

    typedef enum logic [1:0] {
        BRSPC_RUN,
        BRSPC_SUSPEND,
        BRSPC_POWERDOWN
    } brspc_power_e;

    // one two-way pin: drive value, enable, pull-down
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_down;
    } brspc_pin_s;

    // debug mode-select input conditioning
    typedef struct packed {
        logic pull_up;
        logic in_enable;
        logic level;
    } brspc_dbg_s;

    localparam brspc_pin_s DATA_PIN_RESET =
        '{out: 1'h0, oe: 1'h0, pull_down: 1'h1};
    localparam brspc_dbg_s DBG_PIN_RESET =
        '{pull_up: 1'h0, in_enable: 1'h0, level: 1'h0};
endpackage

// ---- core/brspc_pin_ctrl.sv ----
// pin states of the serial rom port across reset and power states
`timescale 1ns/100ps
module brspc_pin_ctrl #(
    parameter int SYNC_STAGES = brspc_pkg::SYNC_DEPTH
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // power state and port enable, same clock
    input wire brspc_pkg::brspc_power_e i_power,
    input wire logic i_port_en,
    // transfer engine pin requests
    input wire logic i_sel_low_req,
    input wire logic i_clk_req,
    input wire logic i_data_req,
    // pin inputs
    input wire logic i_data_pin,
    input wire logic i_rom_serial_in,
    input wire logic i_dbg_pin,
    // pin outputs
    output logic o_rom_select_low,
    output logic o_rom_clk,
    output brspc_pkg::brspc_pin_s o_data,
    output logic o_serial_in_pull_down,
    output brspc_pkg::brspc_dbg_s o_dbg,
    output logic o_rom_serial_in,
    // strap results
    output logic o_rom_speed_strap,
    output logic o_fast_rate
);
    import brspc_pkg::*;

    // slot of each pin in the synchroniser bank
    localparam int PIN_STRAP = 0;
    localparam int PIN_SERIAL_IN = 1;
    localparam int PIN_DEBUG = 2;
    localparam int PIN_COUNT = 3;

    // one stage would hand a metastable level straight to the logic
    if (SYNC_STAGES < 2) begin : g_stage_check
        $error("SYNC_STAGES must be at least 2");
    end

    // rate code for a strap level, shared by rate and suspend decoding
    function automatic logic strap_is_fast(input logic strap);
        return strap == STRAP_FAST;
    endfunction

    // raw pins and their settled copies
    logic [PIN_COUNT-1:0] pin_raw;
    wire [PIN_COUNT-1:0] pin_sync;

    // state registers and their next values
    logic in_reset_reg;
    logic in_reset_next;
    logic strap_reg;
    logic strap_next;
    logic rate_reg;
    logic rate_next;
    logic sel_reg;
    logic sel_next;
    logic clk_reg;
    logic clk_next;
    brspc_pin_s data_reg;
    brspc_pin_s data_next;
    brspc_dbg_s dbg_reg;
    brspc_dbg_s dbg_next;
    logic si_reg;
    logic si_next;
    logic si_pd_reg;
    logic si_pd_next;

    assign pin_raw = {i_dbg_pin, i_rom_serial_in, i_data_pin};

    // pins are outside the clock domain; only the last stage is read
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_sync
        logic [SYNC_STAGES-1:0] stage_reg;
        logic [SYNC_STAGES-1:0] stage_next;

        always_comb begin
            stage_next = {stage_reg[SYNC_STAGES-2:0], pin_raw[g]};
        end

        always_ff @(posedge i_core_clk) begin
            stage_reg <= stage_next;
        end

        assign pin_sync[g] = stage_reg[SYNC_STAGES-1];
    end

    always_comb begin
        in_reset_next = 1'h0;
        strap_next = strap_reg;
        // capture on the first edge after release: the pin floated
        // through reset, so the settled level is the strap, not data
        if (in_reset_reg) begin
            strap_next = pin_sync[PIN_STRAP];
        end
        rate_next = strap_is_fast(strap_next);
        sel_next = 1'h1;
        clk_next = 1'h0;
        data_next = '{out: 1'h0, oe: 1'h0, pull_down: 1'h0};
        dbg_next = '{
            pull_up: 1'h1,
            in_enable: 1'h1,
            level: pin_sync[PIN_DEBUG]
        };
        si_next = pin_sync[PIN_SERIAL_IN];
        si_pd_next = 1'h1;
        unique case (i_power)
            BRSPC_RUN: begin
                // a disabled port parks select high and the clock low
                sel_next = i_port_en ? i_sel_low_req : 1'h1;
                clk_next = i_port_en & i_clk_req;
                data_next.out = i_data_req;
                data_next.oe = 1'h1;
            end
            BRSPC_SUSPEND: begin
                // fast strap frees the pin so its pull-up is not fought
                data_next.oe = !strap_is_fast(strap_next);
            end
            BRSPC_POWERDOWN: begin
                sel_next = 1'h1;
                data_next.oe = 1'h1;
            end
            default: begin
                sel_next = 1'h1;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            in_reset_reg <= 1'h1;
            strap_reg <= STRAP_RESET;
            rate_reg <= strap_is_fast(STRAP_RESET);
            sel_reg <= SEL_RESET;
            clk_reg <= CLK_RESET;
            data_reg <= DATA_PIN_RESET;
            dbg_reg <= DBG_PIN_RESET;
            si_reg <= SERIAL_IN_RESET;
            si_pd_reg <= SI_PULL_RESET;
        end else begin
            in_reset_reg <= in_reset_next;
            strap_reg <= strap_next;
            rate_reg <= rate_next;
            sel_reg <= sel_next;
            clk_reg <= clk_next;
            data_reg <= data_next;
            dbg_reg <= dbg_next;
            si_reg <= si_next;
            si_pd_reg <= si_pd_next;
        end
    end

    assign o_rom_select_low = sel_reg;
    assign o_rom_clk = clk_reg;
    assign o_data = data_reg;
    assign o_serial_in_pull_down = si_pd_reg;
    assign o_dbg = dbg_reg;
    assign o_rom_serial_in = si_reg;
    assign o_rom_speed_strap = strap_reg;
    assign o_fast_rate = rate_reg;

    // the reset pulse width is the system's duty; nothing to count here
    // each check looks one edge after the inputs that cause it

    reset_clk_a: assert property (
        @(posedge i_core_clk) !i_rst_b |=> !o_rom_clk)
        else $error("rom clock not low after reset");

    reset_data_a: assert property (
        @(posedge i_core_clk) !i_rst_b |=> !o_data.oe && o_data.pull_down)
        else $error("data pin not floating with pull-down in reset");

    release_drive_a: assert property (
        @(posedge i_core_clk)
        in_reset_reg && i_rst_b && i_power == BRSPC_RUN
        |=> o_data.oe && !o_data.pull_down)
        else $error("data pin not driven after release");

    release_strap_a: assert property (
        @(posedge i_core_clk) in_reset_reg && i_rst_b
        |=> o_rom_speed_strap == $past(pin_sync[PIN_STRAP]))
        else $error("strap not taken from the pin at release");

    release_pull_a: assert property (
        @(posedge i_core_clk) i_rst_b |=> !o_data.pull_down)
        else $error("data pin pull-down on after release");

    powerdown_sel_a: assert property (
        @(posedge i_core_clk)
        i_rst_b && i_power == BRSPC_POWERDOWN |=> o_rom_select_low)
        else $error("chip select low in power-down");

    suspend_data_a: assert property (
        @(posedge i_core_clk)
        i_rst_b && !in_reset_reg && i_power == BRSPC_SUSPEND
        |=> o_data.oe == (o_rom_speed_strap != STRAP_FAST) && !o_data.out)
        else $error("suspend data pin state wrong for strap");

    strap_hold_a: assert property (
        @(posedge i_core_clk)
        i_rst_b && !in_reset_reg |=> $stable(o_rom_speed_strap))
        else $error("strap changed outside reset release");

    rate_sel_a: assert property (
        @(posedge i_core_clk)
        1'h1 |=> o_fast_rate == (o_rom_speed_strap == STRAP_FAST))
        else $error("rate select disagrees with strap");

    si_pull_a: assert property (
        @(posedge i_core_clk) 1'h1 |=> o_serial_in_pull_down)
        else $error("serial input pull-down off");

    dbg_cond_a: assert property (
        @(posedge i_core_clk)
        !i_rst_b |=> !o_dbg.pull_up && !o_dbg.in_enable)
        else $error("debug input enabled in reset");

    dbg_run_a: assert property (
        @(posedge i_core_clk)
        i_rst_b |=> o_dbg.pull_up && o_dbg.in_enable)
        else $error("debug pull-up or input off in run");
endmodule

// ---- test/brspc_rom_model.sv ----
// serial boot rom model with strap resistor and released lines
`timescale 1ns/100ps
module brspc_rom_model (
    // pins from the block
    input wire logic i_sel_low,
    input wire brspc_pkg::brspc_pin_s i_data,
    // board strap and rom reply
    input wire logic i_strap_up,
    input wire logic i_reply,
    // levels back to the block
    output logic o_data_pin,
    output logic o_serial_out
);
    import brspc_pkg::*;
    // floating pin settles to the strap resistor
    assign o_data_pin = i_data.oe ? i_data.out : i_strap_up;
    // deselected rom releases its line, pull-down wins
    assign o_serial_out = i_sel_low ? 1'h0 : i_reply;
endmodule

// ---- test/boot_rom_spi_pin_control_tb.sv ----
// bench for the serial rom pin control block
`timescale 1ns/100ps
module boot_rom_spi_pin_control_tb;
    import brspc_pkg::*;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    brspc_power_e pwr = BRSPC_RUN;
    logic data_req = 1'h0;
    logic strap_up = 1'h0;
    logic clk_req = 1'h0;
    logic dbg_in = 1'h1;
    logic reply = 1'h1;
    logic data_pin, rom_in, sel_low, rom_clk, sin_pd, syn_in, strap, fast;
    brspc_pin_s data;
    brspc_dbg_s dbg;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    brspc_pin_ctrl u_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_power(pwr),
        .i_port_en(1'h1), .i_sel_low_req(1'h0), .i_clk_req(clk_req),
        .i_data_req(data_req), .i_data_pin(data_pin), .i_rom_serial_in(rom_in),
        .i_dbg_pin(dbg_in), .o_rom_select_low(sel_low), .o_rom_clk(rom_clk),
        .o_data(data), .o_serial_in_pull_down(sin_pd), .o_dbg(dbg),
        .o_rom_serial_in(syn_in), .o_rom_speed_strap(strap), .o_fast_rate(fast));
    brspc_rom_model u_rom (.i_sel_low(sel_low), .i_data(data),
        .i_strap_up(strap_up), .i_reply(reply), .o_data_pin(data_pin),
        .o_serial_out(rom_in));
    task automatic chk(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wait_look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // strap, suspend and power-down for one strap level
    task automatic power_test(input logic up);
        @(posedge clk);
        rst_b <= 1'h0;
        strap_up <= up;
        pwr <= BRSPC_RUN;
        data_req <= 1'h0;
        clk_req <= 1'h1;
        wait_look(RESET_MIN_CYC);
        chk(rom_clk, 1'h0, "clk in reset");
        chk(data.oe, 1'h0, "data oe in reset");
        chk(data.pull_down, 1'h1, "data pull in reset");
        chk(dbg.pull_up | dbg.in_enable | dbg.level, 1'h0, "dbg in reset");
        @(posedge clk);
        rst_b <= 1'h1;
        wait_look(3);
        chk(strap, up, "strap");
        chk(fast, up, "rate");
        chk(rom_clk, 1'h1, "clk after reset");
        chk(data.oe, 1'h1, "data oe run");
        chk(data.pull_down, 1'h0, "data pull run");
        chk(dbg.pull_up & dbg.in_enable, 1'h1, "dbg run");
        @(posedge clk);
        pwr <= BRSPC_SUSPEND;
        strap_up <= ~up;
        wait_look(3);
        chk(data.oe, ~up, "suspend oe");
        chk(data.out, 1'h0, "suspend out");
        @(posedge clk);
        pwr <= BRSPC_POWERDOWN;
        data_req <= 1'h1;
        wait_look(4);
        chk(sel_low, 1'h1, "powerdown select");
        chk(strap, up, "strap held");
        chk(sin_pd, 1'h1, "rom in pull");
        chk(syn_in, 1'h0, "released rom line");
        $display("power test strap %0d done", up);
    endtask
    // pin levels pass in run while the strap stays latched
    task automatic run_test();
        @(posedge clk);
        pwr <= BRSPC_RUN;
        data_req <= 1'h1;
        dbg_in <= 1'h0;
        reply <= 1'h1;
        wait_look(5);
        chk(data.out, 1'h1, "run data out");
        chk(data.pull_down, 1'h0, "run data pull");
        chk(dbg.level, 1'h0, "dbg level low");
        chk(syn_in, 1'h1, "rom line in run");
        @(posedge clk);
        data_req <= 1'h0;
        dbg_in <= 1'h1;
        reply <= 1'h0;
        wait_look(5);
        chk(data.out, 1'h0, "run data out low");
        chk(dbg.level, 1'h1, "dbg level high");
        chk(syn_in, 1'h0, "rom line low");
        chk(strap, 1'h1, "strap kept in run");
        $display("run test done");
    endtask
    initial begin
        power_test(1'h0);
        power_test(1'h1);
        run_test();
        tally_and_finish();
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
endmodule
